/* design/adcc_pkg.sv */
// Package for the converter control block: field layouts, encodings, reset values, state types
package adcc_pkg;
   // Converter timing defaults, in clock and converter-clock cycles
   localparam int ADC_DIV_DEF = 4;
   localparam int CONV_CYC_DEF = 7;
   localparam logic [4:0] GAIN_EXTRA = 5'h01;
   // Field positions inside the 8-bit configuration write data
   localparam int CTRLA_EN_POS = 0;
   localparam int CTRLA_START_POS = 1;
   localparam int CTRLA_INTC_POS = 2;
   localparam int SECOND_CONTROL_REGISTER_SIGNED_POS = 0;
   localparam int SECOND_CONTROL_REGISTER_FREERUN_POS = 1;
   localparam int REF_SRC_POS = 4;
   localparam int CH_MODE_POS = 0;
   localparam int CH_GAIN_POS = 2;
   localparam int MUX_NEG_POS = 0;
   localparam int MUX_POS_POS = 3;
   // Encodings that this revision does not implement, and the gain-stage input mode
   localparam logic [2:0] GAIN_HALF = 3'h7;
   localparam logic [2:0] REF_HALF_SUPPLY = 3'h2;
   localparam logic [2:0] NEG_INTERNAL_GND = 3'h5;
   localparam logic [1:0] MODE_DIFF_GAIN = 2'h3;
   // Values after reset
   localparam logic [2:0] GAIN_RST = 3'h0;
   localparam logic [2:0] REF_RST = 3'h0;
   localparam logic [1:0] MODE_RST = 2'h0;
   localparam logic [11:0] CMP_RST = 12'h000;

   typedef enum logic [2:0] {
      FLD_CTRLA = 3'h0,
      FLD_SECOND_CONTROL_REGISTER = 3'h1,
      FLD_REFERENCE_CONTROL_REGISTER = 3'h2,
      FLD_CHCTRL = 3'h3,
      FLD_INPUT_ROUTING_REGISTER = 3'h4,
      FLD_SWEEP = 3'h5,
      FLD_CMPL = 3'h6,
      FLD_CMPH = 3'h7
   } adcc_field_t;

   typedef enum logic [1:0] {
      INTC_COMPLETE = 2'h0,
      INTC_BELOW = 2'h1,
      INTC_ABOVE = 2'h2
   } adcc_intc_t;

   typedef enum logic {
      ST_IDLE = 1'b0,
      ST_CONV = 1'b1
   } adcc_state_t;

   typedef struct packed {
      logic wr;
      adcc_field_t field;
      logic [7:0] data;
   } adcc_wr_t;

   typedef struct packed {
      logic en;
      logic freerun;
      logic signed_md;
      logic [1:0] intc;
      logic [2:0] ref_src;
      logic [2:0] gain;
      logic [1:0] in_mode;
      logic [3:0] pos_sel;
      logic [2:0] neg_sel;
      logic [11:0] cmp_val;
   } adcc_cfg_t;

   typedef struct packed {
      logic [11:0] data;
      logic valid;
      logic ok;
      logic evt;
   } adcc_res_t;

   typedef struct packed {
      adcc_state_t st;
      adcc_cfg_t cfg;
      logic [7:0] div;
      logic [4:0] ticks;
      logic [4:0] lat;
      logic gain_used;
      logic single;
      adcc_res_t res;
      logic cmp_flag;
      logic busy;
   } adcc_regs_t;
endpackage

/* design/adcc_ctrl.sv */
// Converter control block: configuration filter, conversion sequencing, event and compare flag
// Overview of operation
// - Event output pulses on every completed conversion, whatever the compare condition.
// - Gain stage adds exactly one converter clock of latency for any gain.
// - Single conversions through the gain stage give results with the ok flag cleared (valid still pulses).
// - Writes configuring missing options leave the affected settings unchanged, like reserved locations.
// - Half-gain encoding leaves the channel gain unchanged.
// - Half-supply reference encoding leaves the reference selection unchanged.
// - Internal ground as negative input is refused; the write is ignored.
// - Channel sweep register is absent; its accesses do nothing.
// - Current limit field ignores writes.
// - Gain-stage impedance bit ignores writes.
`timescale 1ns/10ps
`default_nettype none
module adcc_ctrl #(
   parameter int ADC_DIV = adcc_pkg::ADC_DIV_DEF,
   parameter int CONV_CYCLES = adcc_pkg::CONV_CYC_DEF
) (
   input wire logic clk,
   input wire logic srst,
   input wire adcc_pkg::adcc_wr_t cfg_wr,
   input wire logic [11:0] sample_data,
   input wire logic cmp_flag_clr,
   output adcc_pkg::adcc_cfg_t cfg_view,
   output adcc_pkg::adcc_res_t result,
   output logic cmp_flag,
   output logic busy
);
   import adcc_pkg::*;

   adcc_regs_t q_r;
   adcc_regs_t q_nxt;
   logic tick;
   logic done;
   logic begin_conv;

   function automatic logic cmp_hit(input logic [1:0] intc, input logic sgn, input logic [11:0] v,
                                    input logic [11:0] thr);
      logic below;
      below = sgn ? ($signed(v) < $signed(thr)) : (v < thr);
      case (intc)
         INTC_BELOW: cmp_hit = below;
         INTC_ABOVE: cmp_hit = !below && (v != thr);
         default: cmp_hit = 1'b0;
      endcase
   endfunction

   always_comb begin
      q_nxt = q_r;
      q_nxt.res.valid = 1'b0;
      q_nxt.res.evt = 1'b0;
      tick = (q_r.st == ST_CONV) && (q_r.div == 8'(ADC_DIV - 1));
      done = tick && (q_r.ticks == q_r.lat - 5'h01);
      begin_conv = 1'b0;

      // Configuration writes; refused encodings leave the field as it was
      if (cfg_wr.wr) begin
         unique case (cfg_wr.field)
            FLD_CTRLA: begin
               q_nxt.cfg.en = cfg_wr.data[CTRLA_EN_POS];
               q_nxt.cfg.intc = cfg_wr.data[CTRLA_INTC_POS +: 2];
            end
            FLD_SECOND_CONTROL_REGISTER: begin
               // Current limit and impedance bits are not stored at all
               q_nxt.cfg.signed_md = cfg_wr.data[SECOND_CONTROL_REGISTER_SIGNED_POS];
               q_nxt.cfg.freerun = cfg_wr.data[SECOND_CONTROL_REGISTER_FREERUN_POS];
            end
            FLD_REFERENCE_CONTROL_REGISTER: begin
               if (cfg_wr.data[REF_SRC_POS +: 3] != REF_HALF_SUPPLY) begin
                  q_nxt.cfg.ref_src = cfg_wr.data[REF_SRC_POS +: 3];
               end
            end
            FLD_CHCTRL: begin
               q_nxt.cfg.in_mode = cfg_wr.data[CH_MODE_POS +: 2];
               if (cfg_wr.data[CH_GAIN_POS +: 3] != GAIN_HALF) begin
                  q_nxt.cfg.gain = cfg_wr.data[CH_GAIN_POS +: 3];
               end
            end
            FLD_INPUT_ROUTING_REGISTER: begin
               if (cfg_wr.data[MUX_NEG_POS +: 3] != NEG_INTERNAL_GND) begin
                  q_nxt.cfg.neg_sel = cfg_wr.data[MUX_NEG_POS +: 3];
                  q_nxt.cfg.pos_sel = cfg_wr.data[MUX_POS_POS +: 4];
               end
            end
            FLD_SWEEP: begin
               q_nxt.cfg = q_r.cfg;
            end
            FLD_CMPL: q_nxt.cfg.cmp_val[7:0] = cfg_wr.data;
            FLD_CMPH: q_nxt.cfg.cmp_val[11:8] = cfg_wr.data[3:0];
         endcase
      end

      unique case (q_r.st)
         ST_IDLE: begin
            // A start request arriving with the block disabled is dropped, not queued
            if (q_r.cfg.en && (q_r.cfg.freerun ||
                (cfg_wr.wr && cfg_wr.field == FLD_CTRLA && cfg_wr.data[CTRLA_START_POS]))) begin
               begin_conv = 1'b1;
            end
         end
         ST_CONV: begin
            if (tick) begin
               q_nxt.ticks = q_r.ticks + 5'h01;
            end
            q_nxt.div = tick ? 8'h00 : q_r.div + 8'h01;
            if (done) begin
               q_nxt.st = ST_IDLE;
               q_nxt.res.data = sample_data;
               q_nxt.res.valid = 1'b1;
               q_nxt.res.evt = 1'b1;
               q_nxt.res.ok = !(q_r.gain_used && q_r.single);
               // Free-running restarts back to back so the sample rate stays constant
               begin_conv = q_r.cfg.en && q_r.cfg.freerun;
            end
            if (!q_r.cfg.en) begin
               q_nxt.st = ST_IDLE;
            end
         end
      endcase

      if (begin_conv) begin
         q_nxt.st = ST_CONV;
         q_nxt.div = 8'h00;
         q_nxt.ticks = 5'h00;
         q_nxt.gain_used = (q_r.cfg.in_mode == MODE_DIFF_GAIN);
         q_nxt.single = !q_r.cfg.freerun;
         // Latency grows by one converter clock only, whatever the gain
         q_nxt.lat = 5'(CONV_CYCLES) + ((q_r.cfg.in_mode == MODE_DIFF_GAIN) ? GAIN_EXTRA : 5'h00);
      end
      q_nxt.busy = (q_nxt.st == ST_CONV);

      // Clear loses to a set in the same cycle; the event output is not gated here
      if (cmp_flag_clr) begin
         q_nxt.cmp_flag = 1'b0;
      end
      if (done && cmp_hit(q_r.cfg.intc, q_r.cfg.signed_md, sample_data, q_r.cfg.cmp_val)) begin
         q_nxt.cmp_flag = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         q_r <= '0;
         q_r.st <= ST_IDLE;
         q_r.cfg.gain <= GAIN_RST;
         q_r.cfg.ref_src <= REF_RST;
         q_r.cfg.in_mode <= MODE_RST;
         q_r.cfg.cmp_val <= CMP_RST;
         q_r.cfg.intc <= INTC_COMPLETE;
      end else begin
         q_r <= q_nxt;
      end
   end

   assign cfg_view = q_r.cfg;
   assign result = q_r.res;
   assign cmp_flag = q_r.cmp_flag;
   assign busy = q_r.busy;

   // Helper: clock cycles since the current conversion began
   logic [15:0] conv_clk_r;
   always_ff @(posedge clk) begin
      if (srst) begin
         conv_clk_r <= 16'h0000;
      end else begin
         conv_clk_r <= begin_conv ? 16'h0001 : conv_clk_r + 16'h0001;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   a_evt_each_conv: assert property (result.valid |-> result.evt)
      else $error("event missing on completed conversion");
   a_evt_no_gate: assert property (result.valid && (cfg_view.intc != INTC_COMPLETE) |-> result.evt)
      else $error("event gated by compare condition");
   a_gain_latency: assert property (result.valid |->
      $past(conv_clk_r) == 16'(ADC_DIV) * 16'($past(q_r.lat)) &&
      $past(q_r.lat) == 5'(CONV_CYCLES) + ($past(q_r.gain_used) ? GAIN_EXTRA : 5'h00))
      else $error("conversion latency wrong");
   a_single_gain_bad: assert property (done |=> (result.ok == !($past(q_r.gain_used) && $past(q_r.single))))
      else $error("gain-stage single result validity wrong");
   a_half_gain_kept: assert property (cfg_wr.wr && cfg_wr.field == FLD_CHCTRL &&
      cfg_wr.data[CH_GAIN_POS +: 3] == GAIN_HALF |=> $stable(cfg_view.gain))
      else $error("half gain accepted");
   a_half_ref_kept: assert property (cfg_wr.wr && cfg_wr.field == FLD_REFERENCE_CONTROL_REGISTER &&
      cfg_wr.data[REF_SRC_POS +: 3] == REF_HALF_SUPPLY |=> $stable(cfg_view.ref_src))
      else $error("half-supply reference accepted");
   a_gnd_neg_kept: assert property (cfg_wr.wr && cfg_wr.field == FLD_INPUT_ROUTING_REGISTER &&
      cfg_wr.data[MUX_NEG_POS +: 3] == NEG_INTERNAL_GND |=> $stable(cfg_view.neg_sel) && $stable(cfg_view.pos_sel))
      else $error("internal ground negative input accepted");
   a_sweep_inert: assert property (cfg_wr.wr && cfg_wr.field == FLD_SWEEP |=> $stable(cfg_view))
      else $error("sweep write changed configuration");
   a_second_control_register_masked: assert property (cfg_wr.wr && cfg_wr.field == FLD_SECOND_CONTROL_REGISTER |=>
      cfg_view.signed_md == $past(cfg_wr.data[SECOND_CONTROL_REGISTER_SIGNED_POS]) && $stable(cfg_view.gain) &&
      $stable(cfg_view.ref_src))
      else $error("second control write disturbed other settings");
   a_cmp_cause: assert property ($rose(cmp_flag) |-> result.valid && $past(cfg_view.intc) != INTC_COMPLETE)
      else $error("compare flag set without matching conversion");
   a_cmp_set_wins: assert property (done && cmp_flag_clr &&
      cmp_hit(q_r.cfg.intc, q_r.cfg.signed_md, sample_data, q_r.cfg.cmp_val) |=> cmp_flag)
      else $error("compare set lost to clear");
   // The flag is sticky: only a clear in a cycle without a compare hit drops it
   a_cmp_sticky: assert property (cmp_flag && !cmp_flag_clr |=> cmp_flag)
      else $error("compare flag dropped without clear");
   a_cmp_clear: assert property (cmp_flag_clr && !done |=> !cmp_flag)
      else $error("compare flag survived clear");
   a_evt_single: assert property (result.evt |=> !result.evt)
      else $error("event held longer than one cycle");
   a_evt_after_busy: assert property (result.valid |-> $past(busy))
      else $error("completion without a conversion in progress");

   c_gain_freerun: cover property (result.valid && result.ok && $past(q_r.gain_used));
   c_gain_single: cover property (result.valid && !result.ok);
   c_cmp_below: cover property ($rose(cmp_flag) && cfg_view.intc == INTC_BELOW);
   c_back_to_back: cover property (result.valid ##[1:64] result.valid);
   c_set_beats_clr: cover property (done && cmp_flag_clr ##1 cmp_flag);
endmodule
`default_nettype wire

/* testbench/adcc_core_model.sv */
// Behavioural converter core that feeds conversion samples to the control block
`timescale 1ns/10ps
`default_nettype none
module adcc_core_model (
   input wire logic busy,
   input wire logic [11:0] value,
   output logic [11:0] sample_data
);
   // Inverted sample outside a conversion, so a read at the wrong moment shows up
   assign sample_data = busy ? value : ~value;
endmodule
`default_nettype wire

/* testbench/adcc_ctrl_tb.sv */
// Self-checking bench for the converter control block
`timescale 1ns/10ps
`default_nettype none
module adcc_ctrl_tb;
   import adcc_pkg::*;
   localparam int L0 = ADC_DIV_DEF * CONV_CYC_DEF;
   localparam int L1 = ADC_DIV_DEF * (CONV_CYC_DEF + 1);
   logic clk = 1'b0;
   logic srst;
   adcc_wr_t cfg_wr;
   logic [11:0] sample_data;
   logic [11:0] val;
   logic cmp_flag_clr;
   adcc_cfg_t cfg_view;
   adcc_cfg_t exp_cfg;
   adcc_res_t result;
   logic cmp_flag;
   logic busy;
   int err_count = 0;
   int checked = 0;
   int cnt;
   adcc_ctrl #(.ADC_DIV(ADC_DIV_DEF), .CONV_CYCLES(CONV_CYC_DEF)) DUT (.clk(clk), .srst(srst), .cfg_wr(cfg_wr),
      .sample_data(sample_data), .cmp_flag_clr(cmp_flag_clr), .cfg_view(cfg_view),
      .result(result), .cmp_flag(cmp_flag), .busy(busy));
   adcc_core_model core (.busy(busy), .value(val), .sample_data(sample_data));
   always #25 clk = ~clk;
   task automatic conclude();
      if (err_count == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(logic [63:0] g, logic [63:0] e);
      checked++;
      if (g !== e) begin
         err_count++;
         $display("unexpected at %0t: value %h, wanted %h", $time, g, e);
      end
   endtask
   task automatic chk_n(int g, int e);
      checked++;
      if (g != e) begin
         err_count++;
         $display("unexpected at %0t: count %0d, wanted %0d", $time, g, e);
      end
   endtask
   // Strobe low for one edge between writes, so no signal is driven twice at once
   task automatic wr(adcc_field_t f, logic [7:0] d);
      cfg_wr <= '{wr: 1'b1, field: f, data: d};
      @(posedge clk);
      cfg_wr.wr <= 1'b0;
      @(posedge clk);
   endtask
   // Counts edges until a completion shows; outputs are read as they stood before each edge
   task automatic wait_done(int n0, int e);
      cnt = n0;
      while (cnt < 200 && result.valid !== 1'b1) begin
         @(posedge clk);
         cnt++;
      end
      if (cnt >= 200) begin
         err_count++;
         conclude();
      end else begin
         chk_n(cnt, e);
      end
   endtask
   initial begin
      srst <= 1'b1;
      cfg_wr <= '0;
      cmp_flag_clr <= 1'b0;
      val <= 12'h050;
      exp_cfg = '0;
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      chk({cfg_view, result, cmp_flag, busy}, '0);
      wr(FLD_SECOND_CONTROL_REGISTER, 8'he1);
      exp_cfg.signed_md = 1'b1;
      chk(cfg_view, exp_cfg);
      wr(FLD_CHCTRL, 8'h0f);
      wr(FLD_CHCTRL, 8'h1d);
      exp_cfg.gain = 3'h3;
      exp_cfg.in_mode = 2'h1;
      chk(cfg_view, exp_cfg);
      wr(FLD_REFERENCE_CONTROL_REGISTER, 8'h10);
      wr(FLD_REFERENCE_CONTROL_REGISTER, 8'h20);
      exp_cfg.ref_src = 3'h1;
      chk(cfg_view, exp_cfg);
      wr(FLD_INPUT_ROUTING_REGISTER, 8'h11);
      wr(FLD_INPUT_ROUTING_REGISTER, 8'h25);
      exp_cfg.pos_sel = 4'h2;
      exp_cfg.neg_sel = 3'h1;
      chk(cfg_view, exp_cfg);
      wr(FLD_SWEEP, 8'hff);
      chk(cfg_view, exp_cfg);
      wr(FLD_CMPL, 8'h00);
      wr(FLD_CMPH, 8'h01);
      wr(FLD_CHCTRL, 8'h0c);
      wr(FLD_CTRLA, 8'h05);
      exp_cfg.cmp_val = 12'h100;
      exp_cfg.in_mode = 2'h0;
      exp_cfg.en = 1'b1;
      exp_cfg.intc = 2'h1;
      chk(cfg_view, exp_cfg);
      // Complete, below, above low, above high, negative below with the clear held high
      for (int i = 0; i < 5; i++) begin
         val <= (i == 3) ? 12'h1ff : ((i == 4) ? 12'hf00 : 12'h050);
         cmp_flag_clr <= (i == 4);
         wr(FLD_CTRLA, 8'(8'h03 | ((i == 3 ? 2 : i % 3) << 2)));
         wait_done(0, L0);
         chk({result.data, result.ok, result.evt}, {val, 2'b11});
         chk(cmp_flag, i == 1 || i >= 3);
         cmp_flag_clr <= 1'b1;
         @(posedge clk);
         cmp_flag_clr <= 1'b0;
         @(posedge clk);
      end
      for (int g = 1; g < 7; g += 5) begin
         wr(FLD_CHCTRL, 8'(8'h03 | (g << 2)));
         wr(FLD_CTRLA, 8'h03);
         wait_done(0, L1);
         chk({result.ok, result.evt}, 2'b01);
      end
      wr(FLD_SECOND_CONTROL_REGISTER, 8'h03);
      wait_done(0, L1 + 1);
      // Three further free-running results are timed; only the data and ok flag of the last one are checked
      for (int k = 0; k < 3; k++) begin
         @(posedge clk);
         wait_done(1, L1);
      end
      chk({result.data, result.ok}, {val, 1'b1});
      wr(FLD_CTRLA, 8'h00);
      cnt = 0;
      repeat (40) begin
         @(posedge clk);
         if (result.valid !== 1'b0) cnt++;
      end
      chk_n(cnt, 0);
      chk(busy, 1'b0);
      conclude();
   end
endmodule
`default_nettype wire
